// ### logic/rcc_calibration_control.sv
`timescale 1ns/10ps
`include "rcc_cfg.svh"
module rcc_calibration_control #(
  parameter int unsigned CAL_TIMEOUT_CYC =
    `RCC_FORCE_WAIT_MS * 1000 * `RCC_CLK_MHZ
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic [`RCC_ADDR_W-1:0]   reg_addr,
  input  wire rcc_pkg::rcc_byte_t       reg_wdata,
  output rcc_pkg::rcc_byte_t            reg_rdata,
  output logic                          reg_rvalid,
  input  wire logic                     cal_res_we,
  input  wire logic [2:0]               cal_res_idx,
  input  wire rcc_pkg::rcc_byte_t       cal_res_data,
  input  wire logic                     cal_finish,
  output rcc_pkg::rcc_byte_t            upper_margin_offset,
  output rcc_pkg::rcc_byte_t            tank_margin_offset,
  output rcc_pkg::rcc_byte_t            fullscale_current_scale,
  output rcc_pkg::rcc_prof_t            operating_profile,
  output logic [5:0]                    cal_steps,
  output logic                          cal_running,
  output logic                          cal_overdue,
  output logic [39:0]                   mix_active
);
  import rcc_pkg::*;

  localparam logic [`RCC_WAIT_W-1:0] WAIT_MAX =
    `RCC_WAIT_W'(CAL_TIMEOUT_CYC);

  rcc_state_t            state_reg, state_next;
  rcc_byte_t             upper_reg, upper_next;
  rcc_byte_t             tank_reg, tank_next;
  rcc_byte_t             fs_reg, fs_next;
  rcc_prof_t             target_reg, target_next;
  rcc_prof_t             opprof_reg, opprof_next;
  logic [5:0]            cmd_reg, cmd_next;
  logic                  done_reg, done_next;
  logic [`RCC_WAIT_W-1:0] wait_reg, wait_next;
  logic                  overdue_reg, overdue_next;
  rcc_byte_t             rdata_reg, rdata_next;
  logic                  rvalid_reg;
  rcc_byte_t             bank_rdata;
  logic                  idle, busy, host_ok;
  logic                  wr_upper, wr_tank, wr_fs, wr_target, wr_cmd;
  logic                  wr_done, wr_opprof, wr_force, wr_mix, rd_mix;
  logic [5:0]            cmd_wval;

  // ==========================================================
  // address decode
  assign idle    = (state_reg == RCC_IDLE);
  assign busy    = !idle;
  assign host_ok = reg_wr && idle;   // controller owns the bank while busy
  always_comb begin
    wr_upper  = 1'b0;
    wr_tank   = 1'b0;
    wr_fs     = 1'b0;
    wr_target = 1'b0;
    wr_cmd    = 1'b0;
    wr_done   = 1'b0;
    wr_opprof = 1'b0;
    wr_force  = 1'b0;
    wr_mix    = 1'b0;
    if (reg_addr == `RCC_UPPER_ADDR) wr_upper = host_ok; // R1
    else if (reg_addr == `RCC_TANK_ADDR) wr_tank = host_ok; // R2
    else if (reg_addr == `RCC_FS_ADDR) wr_fs = host_ok; // R3
    else if (reg_addr == `RCC_TARGET_ADDR) wr_target = host_ok; // R6
    else if (reg_addr == `RCC_CMD_ADDR) wr_cmd = host_ok;
    else if (reg_addr == `RCC_DONE_ADDR) wr_done = host_ok;
    else if (reg_addr == `RCC_OPPROF_ADDR) wr_opprof = host_ok; // R12
    else if (reg_addr == `RCC_FORCE_ADDR) wr_force = reg_wr && busy; // R16
    else if (reg_addr >= `RCC_MIX_FIRST && reg_addr <= `RCC_MIX_LAST)
      wr_mix = host_ok; // R7
  end
  assign rd_mix = (reg_addr >= `RCC_MIX_FIRST) &&
                  (reg_addr <= `RCC_MIX_LAST);
  assign cmd_wval = 6'(reg_wdata & `RCC_CMD_MASK);

  // ==========================================================
  // calibration sequencer and its command and done flags
  always_comb begin
    state_next = state_reg;
    cmd_next   = cmd_reg;
    done_next  = done_reg;
    if (wr_done) done_next = reg_wdata[`RCC_DONE_BIT];
    case (state_reg)
      RCC_IDLE: begin
        if (wr_cmd) begin
          cmd_next = cmd_wval;
          if (cmd_wval != 6'h00) begin
            state_next = RCC_RUN; // R8
            done_next  = 1'b0; // R11
          end
        end
      end
      RCC_RUN: begin
        if (cal_finish) begin
          state_next = RCC_IDLE;
          cmd_next   = 6'h00; // R9
          done_next  = 1'b1; // R10
        end else if (wr_force && reg_wdata[`RCC_FORCE_BIT]) begin
          state_next = RCC_FORCE; // R15
        end
      end
      RCC_FORCE: begin
        if (cal_finish) begin
          state_next = RCC_IDLE;
          cmd_next   = 6'h00; // R9
          done_next  = 1'b1; // R10
        end else if (wr_force && !reg_wdata[`RCC_FORCE_BIT]) begin
          state_next = RCC_IDLE; // R15
          cmd_next   = 6'h00; // R9
        end
      end
      default: begin
        state_next = RCC_IDLE;
        cmd_next   = 6'h00;
      end
    endcase
  end

  // plain configuration registers and the overdue watch
  always_comb begin
    upper_next   = wr_upper ? reg_wdata : upper_reg; // R1
    tank_next    = wr_tank ? reg_wdata : tank_reg; // R2
    fs_next      = wr_fs ? reg_wdata : fs_reg; // R3
    target_next  = wr_target ? reg_wdata[1:0] : target_reg; // R6
    opprof_next  = wr_opprof ? reg_wdata[1:0] : opprof_reg; // R12
    wait_next    = '0;
    overdue_next = 1'b0;
    if (busy && state_next != RCC_IDLE) begin
      wait_next    = (wait_reg == WAIT_MAX) ? wait_reg : wait_reg + 1'b1;
      overdue_next = (wait_reg == WAIT_MAX);
    end
  end

  // read path; operating profile is write-only and reads zero
  always_comb begin
    rdata_next = 8'h00;
    if (reg_addr == `RCC_UPPER_ADDR) rdata_next = upper_reg;
    else if (reg_addr == `RCC_TANK_ADDR) rdata_next = tank_reg;
    else if (reg_addr == `RCC_FS_ADDR) rdata_next = fs_reg;
    else if (reg_addr == `RCC_TARGET_ADDR) rdata_next = {6'h00, target_reg};
    else if (reg_addr == `RCC_CMD_ADDR) rdata_next = {2'b00, cmd_reg};
    else if (reg_addr == `RCC_DONE_ADDR) rdata_next = {7'h00, done_reg};
    else if (reg_addr == `RCC_FORCE_ADDR)
      rdata_next = {7'h00, state_reg == RCC_FORCE}; // R16
    else if (rd_mix) rdata_next = bank_rdata;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= RCC_IDLE;
      upper_reg   <= `RCC_UPPER_RST;
      tank_reg    <= `RCC_TANK_RST;
      fs_reg      <= `RCC_FS_RST;
      target_reg  <= 2'h0;
      opprof_reg  <= 2'h0;
      cmd_reg     <= 6'h00;
      done_reg    <= 1'b0;
      wait_reg    <= '0;
      overdue_reg <= 1'b0;
      rdata_reg   <= 8'h00;
      rvalid_reg  <= 1'b0;
    end else begin
      state_reg   <= state_next;
      upper_reg   <= upper_next;
      tank_reg    <= tank_next;
      fs_reg      <= fs_next;
      target_reg  <= target_next;
      opprof_reg  <= opprof_next;
      cmd_reg     <= cmd_next;
      done_reg    <= done_next;
      wait_reg    <= wait_next;
      overdue_reg <= overdue_next;
      rdata_reg   <= reg_rd ? rdata_next : rdata_reg;
      rvalid_reg  <= reg_rd;
    end
  end

  // ==========================================================
  // profile copies of the mixer bytes
  rcc_profile_bank u_bank (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .host_we    (wr_mix),
    .host_idx   (3'(reg_addr - `RCC_MIX_FIRST)),
    .host_wdata (reg_wdata),
    .cal_we     (cal_res_we && busy), // R17
    .cal_idx    (cal_res_idx),
    .cal_wdata  (cal_res_data),
    .cal_prof   (target_reg),
    .op_prof    (opprof_reg),
    .host_rdata (bank_rdata),
    .mix_active (mix_active)
  );

  // outputs straight from registers; fs code / 16 = feedback mA
  assign upper_margin_offset     = upper_reg;
  assign tank_margin_offset      = tank_reg;
  assign fullscale_current_scale = fs_reg; // R4
  assign operating_profile       = opprof_reg;
  assign cal_steps               = cmd_reg;
  assign cal_running             = state_reg != RCC_IDLE;
  assign cal_overdue             = overdue_reg;
  assign reg_rdata               = rdata_reg;
  assign reg_rvalid              = rvalid_reg;

  // ==========================================================
  // checks
  cal_start_a: assert property ( // R8
    @(posedge clk_sys) disable iff (!rst_n)
    (idle && reg_wr && reg_addr == `RCC_CMD_ADDR && reg_wdata[5:0] != 6'h00)
      |=> cal_running && cal_steps == $past(reg_wdata[5:0]))
    else $error("command write did not start calibration");
  cmd_clear_a: assert property ( // R9
    @(posedge clk_sys) disable iff (!rst_n)
    (busy && cal_finish) |=> cal_steps == 6'h00 && !cal_running)
    else $error("command not cleared at calibration end");
  done_set_a: assert property ( // R10
    @(posedge clk_sys) disable iff (!rst_n)
    (busy && cal_finish) |=> done_reg ##1
      (done_reg || $past(wr_done) || $past(wr_cmd)))
    else $error("done flag not set at calibration end");
  done_clear_a: assert property ( // R11
    @(posedge clk_sys) disable iff (!rst_n)
    (idle && reg_wr && reg_addr == `RCC_CMD_ADDR && reg_wdata[5:0] != 6'h00)
      |=> !done_reg)
    else $error("done flag survived a new command");
  force_end_a: assert property ( // R15
    @(posedge clk_sys) disable iff (!rst_n)
    (state_reg == RCC_FORCE && wr_force && !reg_wdata[0] && !cal_finish)
      |=> !cal_running && cal_steps == 6'h00 && $stable(done_reg))
    else $error("force-end sequence did not stop calibration");
  force_gate_a: assert property ( // R16
    @(posedge clk_sys) disable iff (!rst_n)
    (idle && reg_wr && reg_addr == `RCC_FORCE_ADDR)
      |-> !wr_force ##1 !cal_running)
    else $error("force-end reached while idle");
  target_hold_a: assert property ( // R17
    @(posedge clk_sys) disable iff (!rst_n)
    busy |=> $stable(target_reg) || !$past(cal_running))
    else $error("calibration target moved during calibration");
  margin_write_a: assert property ( // R1
    @(posedge clk_sys) disable iff (!rst_n)
    (idle && reg_wr && reg_addr == `RCC_UPPER_ADDR)
      |=> upper_margin_offset == $past(reg_wdata))
    else $error("upper margin write lost");
  opprof_write_a: assert property ( // R12
    @(posedge clk_sys) disable iff (!rst_n)
    (idle && reg_wr && reg_addr == `RCC_OPPROF_ADDR)
      |=> operating_profile == $past(reg_wdata[1:0]))
    else $error("operating profile write lost");
endmodule : rcc_calibration_control

// ### logic/rcc_cfg.svh
`ifndef RCC_CFG_SVH
`define RCC_CFG_SVH
// Operation
// R1: upper margin, 8 bits, 1 MHz steps, reset 5; larger raises frequency.
// R2: LC tank margin, 8 bits, 1 MHz steps, reset 0; larger raises frequency.
// R3: full-scale current code, 8 bits, nominal 0x40 gives 4 mA, largest level.
// R4: code is proportional: 0x20 gives 2 mA, 0x10 gives 1 mA.
// R5: host keeps full-scale reduction at 12 dB or less.
// R6: 2-bit target field picks which profile copy takes calibration results.
// R7: four profiles each hold their own mixer tuning and phase bytes.
// R8: writing one to any of six command bits starts calibration.
// R9: command register clears itself at calibration end or forced end.
// R10: done flag bit 0 sets when the controller finishes calibrating.
// R11: done flag clears whenever a new calibration command is written.
// R12: write-only 2-bit operating profile, reset 0, picks profile in use.
// R13: host switches only to profiles already calibrated.
// R14: operating profile also selects that profile's mixer byte copy.
// R15: force-end written high then low stops calibration; host waits 400 ms.
// R16: force-end control reachable only while calibration is running.
// R17: results land only in the target profile copy; others unchanged.

// ==========================================================
// register offsets
`define RCC_ADDR_W        12
`define RCC_UPPER_ADDR    12'h108
`define RCC_TANK_ADDR     12'h109
`define RCC_FS_ADDR       12'h10a
`define RCC_TARGET_ADDR   12'h115
`define RCC_CMD_ADDR      12'h116
`define RCC_DONE_ADDR     12'h117
`define RCC_OPPROF_ADDR   12'h118
`define RCC_FORCE_ADDR    12'h11a
`define RCC_MIX_FIRST     12'h141
`define RCC_MIX_LAST      12'h145

// ==========================================================
// reset values and field masks
`define RCC_UPPER_RST     8'h05
`define RCC_TANK_RST      8'h00
`define RCC_FS_RST        8'h40
`define RCC_PROF_MASK     8'h03
`define RCC_CMD_MASK      8'h3f
`define RCC_DONE_BIT      0
`define RCC_FORCE_BIT     0
`define RCC_MIX0_P0_RST   8'h05
`define RCC_MIX1_P0_RST   8'h15
`define RCC_MIX_MASK0     8'h3f
`define RCC_MIX_MASK1     8'hff
`define RCC_MIX_MASK2     8'h3f
`define RCC_MIX_MASK3     8'hff
`define RCC_MIX_MASK4     8'h03
`define RCC_MIX_ENTRIES   5
`define RCC_PROFILES      4

// ==========================================================
// timing
`define RCC_CLK_MHZ       125
`define RCC_FORCE_WAIT_MS 400
`define RCC_WAIT_W        26
`endif

// ### logic/rcc_pkg.sv
package rcc_pkg;
  // ==========================================================
  // types
  typedef logic [7:0] rcc_byte_t;
  typedef logic [1:0] rcc_prof_t;
  typedef enum logic [1:0] {
    RCC_IDLE  = 2'b00,
    RCC_RUN   = 2'b01,
    RCC_FORCE = 2'b10
  } rcc_state_t;
endpackage : rcc_pkg

// ### logic/rcc_profile_bank.sv
`timescale 1ns/10ps
`include "rcc_cfg.svh"
module rcc_profile_bank (
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  input  wire logic            host_we,
  input  wire logic [2:0]      host_idx,
  input  wire rcc_pkg::rcc_byte_t host_wdata,
  input  wire logic            cal_we,
  input  wire logic [2:0]      cal_idx,
  input  wire rcc_pkg::rcc_byte_t cal_wdata,
  input  wire rcc_pkg::rcc_prof_t cal_prof,
  input  wire rcc_pkg::rcc_prof_t op_prof,
  output rcc_pkg::rcc_byte_t   host_rdata,
  output logic [39:0]          mix_active
);
  import rcc_pkg::*;

  rcc_byte_t   mem_reg [`RCC_PROFILES][`RCC_MIX_ENTRIES];
  logic [39:0] mix_active_next;

  function automatic rcc_byte_t mix_mask(input int e);
    case (e)
      0:       mix_mask = `RCC_MIX_MASK0;
      1:       mix_mask = `RCC_MIX_MASK1;
      2:       mix_mask = `RCC_MIX_MASK2;
      3:       mix_mask = `RCC_MIX_MASK3;
      default: mix_mask = `RCC_MIX_MASK4;
    endcase
  endfunction : mix_mask

  function automatic rcc_byte_t mix_rst(input int p, input int e);
    if (p == 0 && e == 0) mix_rst = `RCC_MIX0_P0_RST;
    else if (p == 0 && e == 1) mix_rst = `RCC_MIX1_P0_RST;
    else mix_rst = 8'h00;
  endfunction : mix_rst

  // ==========================================================
  // per-profile, per-entry storage
  genvar p, e;
  generate
    for (p = 0; p < `RCC_PROFILES; p++) begin : g_prof
      for (e = 0; e < `RCC_MIX_ENTRIES; e++) begin : g_ent
        rcc_byte_t ent_next;
        // calibration writes only its target copy, host the active one
        always_comb begin
          ent_next = mem_reg[p][e];
          if (cal_we && cal_prof == 2'(p) && cal_idx == 3'(e)) begin // R17
            ent_next = cal_wdata & mix_mask(e); // R6
          end else if (host_we && op_prof == 2'(p) &&
                       host_idx == 3'(e)) begin // R7
            ent_next = host_wdata & mix_mask(e);
          end
        end
        always_ff @(posedge clk_sys or negedge rst_n) begin
          if (!rst_n) mem_reg[p][e] <= mix_rst(p, e);
          else mem_reg[p][e] <= ent_next;
        end
      end
    end
  endgenerate

  // host read port and registered mixer settings of the active profile
  always_comb begin
    host_rdata = 8'h00;
    if (host_idx < 3'(`RCC_MIX_ENTRIES)) begin
      host_rdata = mem_reg[op_prof][host_idx];
    end
    mix_active_next = {mem_reg[op_prof][4], mem_reg[op_prof][3],
                       mem_reg[op_prof][2], mem_reg[op_prof][1],
                       mem_reg[op_prof][0]}; // R14
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) mix_active <= {8'h00, 8'h00, 8'h00,
                               `RCC_MIX1_P0_RST, `RCC_MIX0_P0_RST};
    else mix_active <= mix_active_next;
  end

  cal_isolate_a: assert property ( // R17
    @(posedge clk_sys) disable iff (!rst_n)
    (cal_we && !host_we && cal_prof != 2'd0)
      |=> $stable(mem_reg[0][0]) && $stable(mem_reg[0][1]))
    else $error("calibration result reached a non-target profile");
endmodule : rcc_profile_bank

// ### test/rcc_calibration_control_tb.sv
`timescale 1ns/10ps
`include "rcc_cfg.svh"
module rcc_calibration_control_tb;
  import rcc_pkg::*;
  localparam int unsigned TMO = 20;
  logic clk_sys, rst_n, reg_wr, reg_rd, reg_rvalid;
  logic cal_res_we, cal_finish, cal_running, cal_overdue;
  logic [11:0] reg_addr;
  logic [2:0]  cal_res_idx;
  logic [5:0]  cal_steps;
  logic [39:0] mix_active;
  rcc_byte_t   reg_wdata, reg_rdata, cal_res_data, rv;
  rcc_byte_t   upper_margin_offset, tank_margin_offset;
  rcc_byte_t   fullscale_current_scale;
  rcc_prof_t   operating_profile;
  int          mismatches = 0;
  int          checked = 0;

  // ==========================================================
  // clock
  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;

  rcc_calibration_control #(.CAL_TIMEOUT_CYC(TMO)) u_rcc_calibration_control (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .cal_res_we(cal_res_we),
    .cal_res_idx(cal_res_idx), .cal_res_data(cal_res_data),
    .cal_finish(cal_finish), .upper_margin_offset(upper_margin_offset),
    .tank_margin_offset(tank_margin_offset),
    .fullscale_current_scale(fullscale_current_scale),
    .operating_profile(operating_profile), .cal_steps(cal_steps),
    .cal_running(cal_running), .cal_overdue(cal_overdue),
    .mix_active(mix_active));

  rcc_host_model u_rcc_host_model (
    .clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .cal_res_we(cal_res_we),
    .cal_res_idx(cal_res_idx), .cal_res_data(cal_res_data),
    .cal_finish(cal_finish));

  // ==========================================================
  // comparison helpers
  task automatic chk(input logic [39:0] got, input logic [39:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic rc(input logic [11:0] a, input rcc_byte_t e);
    u_rcc_host_model.rd(a, rv);
    chk({39'h0, reg_rvalid}, 40'h1, "rvalid");
    chk(rv, e, $sformatf("read %h", a));
  endtask : rc

  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk(upper_margin_offset, 8'h05, "upper port");
    chk(tank_margin_offset, 8'h00, "tank port");
    chk(fullscale_current_scale, 8'h40, "fs port");
    chk(operating_profile, 2'h0, "profile port");
    chk(mix_active, 40'h00_0000_1505, "mixer reset");
    rc(`RCC_UPPER_ADDR, 8'h05);
    rc(`RCC_TANK_ADDR, 8'h00);
    rc(`RCC_FS_ADDR, 8'h40);
    rc(`RCC_TARGET_ADDR, 8'h00);
    rc(`RCC_CMD_ADDR, 8'h00);
    rc(`RCC_DONE_ADDR, 8'h00);
    rc(`RCC_OPPROF_ADDR, 8'h00);
    rc(12'h200, 8'h00);
  endtask : t_reset

  task automatic t_config();
    u_rcc_host_model.wr(`RCC_UPPER_ADDR, 8'hff);
    chk(upper_margin_offset, 8'hff, "upper max");
    rc(`RCC_UPPER_ADDR, 8'hff);
    u_rcc_host_model.wr(`RCC_TANK_ADDR, 8'h3c);
    chk(tank_margin_offset, 8'h3c, "tank write");
    u_rcc_host_model.wr(`RCC_FS_ADDR, 8'h20);
    chk(fullscale_current_scale, 8'h20, "fs half");
    u_rcc_host_model.wr(`RCC_FS_ADDR, 8'h10);
    rc(`RCC_FS_ADDR, 8'h10);
    u_rcc_host_model.wr(`RCC_TARGET_ADDR, 8'hff);
    rc(`RCC_TARGET_ADDR, 8'h03);
    u_rcc_host_model.wr(`RCC_OPPROF_ADDR, 8'h07);
    chk(operating_profile, 2'h3, "profile select");
    rc(`RCC_OPPROF_ADDR, 8'h00);
    u_rcc_host_model.wr(`RCC_OPPROF_ADDR, 8'h00);
  endtask : t_config

  task automatic t_cal();
    u_rcc_host_model.wr(`RCC_TARGET_ADDR, 8'h02);
    u_rcc_host_model.wr(`RCC_CMD_ADDR, 8'hff);
    chk({cal_running, cal_steps}, 7'h7f, "cal start");
    u_rcc_host_model.wr(`RCC_UPPER_ADDR, 8'h77);
    u_rcc_host_model.res(3'h1, 8'h22);
    u_rcc_host_model.fin();
    chk({cal_running, cal_steps}, 7'h00, "cal end");
    rc(`RCC_DONE_ADDR, 8'h01);
    rc(`RCC_UPPER_ADDR, 8'hff);
    chk(mix_active, 40'h00_0000_1505, "other copy");
    rc(12'h142, 8'h15);
    u_rcc_host_model.res(3'h1, 8'h55);
    u_rcc_host_model.wr(`RCC_OPPROF_ADDR, 8'h02);
    repeat (3) @(negedge clk_sys);
    chk(mix_active, 40'h00_0000_2200, "profile mixer");
    rc(12'h142, 8'h22);
    u_rcc_host_model.wr(`RCC_MIX_FIRST, 8'hff);
    rc(`RCC_MIX_FIRST, 8'h3f);
  endtask : t_cal

  task automatic t_force();
    u_rcc_host_model.wr(`RCC_FORCE_ADDR, 8'h01);
    rc(`RCC_FORCE_ADDR, 8'h00);
    chk(cal_running, 1'b0, "idle force");
    u_rcc_host_model.wr(`RCC_CMD_ADDR, 8'h01);
    rc(`RCC_DONE_ADDR, 8'h00);
    repeat (TMO + 5) @(negedge clk_sys);
    chk(cal_overdue, 1'b1, "overdue");
    u_rcc_host_model.wr(`RCC_FORCE_ADDR, 8'h01);
    rc(`RCC_FORCE_ADDR, 8'h01);
    u_rcc_host_model.wr(`RCC_FORCE_ADDR, 8'h00);
    chk({cal_running, cal_steps}, 7'h00, "force end");
    rc(`RCC_CMD_ADDR, 8'h00);
    rc(`RCC_DONE_ADDR, 8'h00);
  endtask : t_force

  // ==========================================================
  // verdict
  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // watchdog well beyond the roughly 115 cycles the run needs
  initial begin
    repeat (3000) @(posedge clk_sys);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset();
    t_config();
    t_cal();
    t_force();
    final_report();
  end
endmodule : rcc_calibration_control_tb

// ### test/rcc_host_model.sv
`timescale 1ns/10ps
module rcc_host_model (
  input  wire logic               clk_sys,
  output logic                    reg_wr,
  output logic                    reg_rd,
  output logic [11:0]             reg_addr,
  output rcc_pkg::rcc_byte_t      reg_wdata,
  input  wire rcc_pkg::rcc_byte_t reg_rdata,
  input  wire logic               reg_rvalid,
  output logic                    cal_res_we,
  output logic [2:0]              cal_res_idx,
  output rcc_pkg::rcc_byte_t      cal_res_data,
  output logic                    cal_finish
);
  import rcc_pkg::*;
  // ==========================================================
  // idle levels from time zero
  initial begin
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    reg_addr     = 12'h000;
    reg_wdata    = 8'h00;
    cal_res_we   = 1'b0;
    cal_res_idx  = 3'h0;
    cal_res_data = 8'h00;
    cal_finish   = 1'b0;
  end

  // ==========================================================
  // host accesses, one strobe cycle each, launched off the falling edge
  task automatic wr(input logic [11:0] a, input rcc_byte_t d);
    @(negedge clk_sys);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr    = 1'b0;
    reg_wdata = ~d; // released data no longer shows the last value
  endtask : wr

  // read data is taken once the strobe edge has passed
  task automatic rd(input logic [11:0] a, output rcc_byte_t d);
    @(negedge clk_sys);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    d      = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask : rd

  // ==========================================================
  // calibration engine side: one result byte, or the finish pulse
  task automatic res(input logic [2:0] i, input rcc_byte_t d);
    @(negedge clk_sys);
    cal_res_we   = 1'b1;
    cal_res_idx  = i;
    cal_res_data = d;
    @(negedge clk_sys);
    cal_res_we   = 1'b0;
    cal_res_data = ~d;
  endtask : res

  task automatic fin();
    @(negedge clk_sys);
    cal_finish = 1'b1;
    @(negedge clk_sys);
    cal_finish = 1'b0;
  endtask : fin
endmodule : rcc_host_model
